// File: bench/afr_adc_model.sv
// converter front end model: sends a burst of rising sample values
// assumes the chain's sampleReady backpressure; holds a sample until taken
`timescale 1ns/1ns
`default_nettype none
module afr_adc_model
  import afr_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    go,
  input  wire logic                    rateFast,
  input  wire logic [15:0]             level,
  input  wire logic [7:0]              count,
  input  wire logic                    sampleReady,
  output var  afr_pkg::afr_sample_type sampleIn,
  output var  logic                    busy
);
  logic [7:0]  left;
  logic [15:0] idx;
  logic [1:0]  gapCnt;
  assign busy = left != 8'h0;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sampleIn <= '0;
      left     <= '0;
      gapCnt   <= '0;
    end else if (go) begin
      left <= count;
      idx  <= '0;
    end else if (sampleIn.valid) begin
      // data goes stale once taken, so show its inverse
      if (sampleReady) begin
        sampleIn <= {1'b0, ~sampleIn.data};
        left     <= left - 8'h1;
        idx      <= idx + 16'h1;
        gapCnt   <= rateFast ? 2'h1 : 2'h3;
      end
    end else if (gapCnt != 2'h0) begin
      gapCnt <= gapCnt - 2'h1;
    end else if (left != 8'h0) begin
      sampleIn <= {1'b1, level + idx};
    end
  end
endmodule
`default_nettype wire

// File: bench/afr_chain_properties.sv
// concurrent checks on the filter chain register window and stream
// assumes it is bound to afr_chain and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module afr_chain_properties
  import afr_pkg::*;
(
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire afr_pkg::afr_sample_type  tempIn,
  input wire afr_pkg::afr_dft_res_type dftResult,
  input wire afr_pkg::afr_sample_type  xformOut,
  input wire logic                     xformReady,
  input wire logic                     converterRateSel,
  input wire logic [3:0]               transformPoints,
  input wire logic                     hanningEnable,
  input wire afr_pkg::afr_bus_req_type bus,
  input wire afr_pkg::afr_bus_rsp_type busRsp
);
  logic [15:0] tempSeen_q;
  logic [17:0] reSeen_q;
  logic [17:0] imSeen_q;
  logic        rateSeen_q;
  wire  logic  rdAns = bus.read && !busRsp.waitrequest;
  wire  logic  cfgWrite = bus.write && !busRsp.waitrequest &&
               bus.address == OFS_FILTER_CFG && bus.byteenable[0];

  // shadow copies of what the temperature, real and imaginary results and the rate select should show
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tempSeen_q <= '0;
      reSeen_q   <= '0;
      imSeen_q   <= '0;
      rateSeen_q <= 1'b0;
    end else begin
      if (tempIn.valid) tempSeen_q <= tempIn.data;
      if (dftResult.valid) reSeen_q <= dftResult.re;
      if (dftResult.valid) imSeen_q <= dftResult.im;
      if (cfgWrite) rateSeen_q <= bus.writedata[BIT_RATE_SEL];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_taken;
    (bus.read || bus.write) && busRsp.waitrequest;
  endsequence
  sequence s_answer;
    !busRsp.waitrequest;
  endsequence

  a_bus_answer: assert property (
    s_taken |=> s_answer ##1 busRsp.waitrequest)
    else $error("bus answer not a single cycle after request");
  a_ack_cause: assert property (
    s_answer |-> $past(bus.read || bus.write))
    else $error("answer without a request");
  a_rate_follows: assert property (
    cfgWrite |=> ##1 converterRateSel == rateSeen_q)
    else $error("rate select does not follow config write");
  a_reset_values: assert property (disable iff (1'b0)
    !rst_n |=> transformPoints == 4'h9 && !hanningEnable &&
    !converterRateSel)
    else $error("transform config outputs wrong after reset");
  a_conv_reserved: assert property (
    rdAns && bus.address == OFS_CONV_RESULT |->
    busRsp.readdata[31:16] == 16'h0)
    else $error("converter result upper bits not zero");
  a_notch_reserved: assert property (
    rdAns && bus.address == OFS_NOTCH_RESULT |->
    busRsp.readdata[31:16] == 16'h0)
    else $error("notch result upper bits not zero");
  a_temp_value: assert property (
    rdAns && bus.address == OFS_TEMP_RESULT |->
    busRsp.readdata == {16'h0, tempSeen_q})
    else $error("temperature result differs from last sample");
  a_real_value: assert property (
    rdAns && bus.address == OFS_XFORM_REAL |->
    busRsp.readdata == {14'h0, reSeen_q})
    else $error("real result differs from last transform");
  a_imag_value: assert property (
    rdAns && bus.address == OFS_XFORM_IMAG |->
    busRsp.readdata == {14'h0, imSeen_q})
    else $error("imaginary result differs from last transform");
  a_stream_hold: assert property (
    xformOut.valid && !xformReady |=>
    xformOut.valid && $stable(xformOut.data))
    else $error("stalled transform word changed");
  a_xcfg_reserved: assert property (
    rdAns && bus.address == OFS_XFORM_CFG |->
    (busRsp.readdata & ~MASK_XFORM_CFG) == 32'h0)
    else $error("transform config reserved bits not zero");
endmodule
`default_nettype wire

// File: bench/afr_chain_tb.sv
// self-checking bench for the filter chain: registers, paths, buffer
// assumes the front end model and the bound property checker
`timescale 1ns/1ns
`default_nettype none
module afr_chain_tb;
  import afr_pkg::*;
  logic            ref_clk = 1'b0;
  logic            rst_n;
  afr_sample_type  sampleIn;
  afr_sample_type  tempIn;
  afr_sample_type  xformOut;
  afr_dft_res_type dftResult;
  afr_bus_req_type bus;
  afr_bus_rsp_type busRsp;
  logic            sampleReady;
  logic            xformReady;
  logic            converterRateSel;
  logic            hanningEnable;
  logic [3:0]      transformPoints;
  logic            go;
  logic            modelBusy;
  logic [15:0]     level;
  logic [15:0]     lastData;
  logic [7:0]      count;
  logic [31:0]     rdData;
  int              popCnt;
  int              errorCnt;
  int              totalChecks;
  logic [15:0]     avgLast [4] = '{16'h0407, 16'h0406, 16'h0405, 16'h0403};
  logic [15:0]     resOfs [5] = '{OFS_CONV_RESULT, OFS_XFORM_REAL,
                    OFS_XFORM_IMAG, OFS_NOTCH_RESULT, OFS_TEMP_RESULT};

  always #2 ref_clk = ~ref_clk;

  afr_chain afr_chain_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .sampleIn(sampleIn), .sampleReady(sampleReady), .tempIn(tempIn),
    .dftResult(dftResult), .xformOut(xformOut), .xformReady(xformReady),
    .converterRateSel(converterRateSel), .hanningEnable(hanningEnable),
    .transformPoints(transformPoints), .bus(bus), .busRsp(busRsp));

  afr_adc_model afr_adc_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .go(go), .rateFast(converterRateSel), .level(level), .count(count),
    .sampleReady(sampleReady), .sampleIn(sampleIn), .busy(modelBusy));

  always @(posedge ref_clk) begin
    if (xformOut.valid && xformReady) begin
      popCnt   <= popCnt + 1;
      lastData <= xformOut.data;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stopTest();
    $display("checks=%0d errors=%0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    bus.read      <= !w;
    bus.write     <= w;
    bus.address   <= a;
    bus.writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (busRsp.waitrequest !== 1'b0);
    rdData = busRsp.readdata;
    bus.read  <= 1'b0;
    bus.write <= 1'b0;
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rdData, e);
  endtask

  task automatic send(input logic [15:0] v, input logic [7:0] n);
    @(posedge ref_clk);
    level  <= v;
    count  <= n;
    go     <= 1'b1;
    popCnt <= 0;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (modelBusy) @(posedge ref_clk);
    // long enough for the averaging stage to flush its last group
    repeat (60) @(posedge ref_clk);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errorCnt++;
    stopTest();
  end

  initial begin
    rst_n = 1'b0;
    bus = '0;
    bus.byteenable = 4'hF;
    tempIn = '0;
    dftResult = '0;
    xformReady = 1'b1;
    go = 1'b0;
    level = '0;
    count = '0;
    popCnt = 0;
    lastData = '0;
    errorCnt = 0;
    totalChecks = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdChk(OFS_FILTER_CFG, RST_FILTER_CFG);
    rdChk(OFS_XFORM_CFG, 32'h0000_0090);
    foreach (resOfs[i]) rdChk(resOfs[i], 32'h0);
    rdChk(16'h2000, 32'h0);
    xfer(1'b1, OFS_XFORM_CFG, 32'hFFFF_FFFF);
    rdChk(OFS_XFORM_CFG, 32'h0030_00F1);
    check({27'h0, transformPoints, hanningEnable}, 32'h1F);
    xfer(1'b1, OFS_XFORM_CFG, 32'h0020_0090);
    @(posedge ref_clk);
    tempIn    <= '{1'b1, 16'hA5C3};
    dftResult <= '{1'b1, 18'h2ABCD, 18'h12345};
    @(posedge ref_clk);
    tempIn.valid    <= 1'b0;
    dftResult.valid <= 1'b0;
    rdChk(OFS_TEMP_RESULT, 32'h0000_A5C3);
    xfer(1'b1, OFS_TEMP_RESULT, 32'hFFFF_FFFF);
    rdChk(OFS_TEMP_RESULT, 32'h0000_A5C3);
    rdChk(OFS_XFORM_REAL, 32'h0002_ABCD);
    rdChk(OFS_XFORM_IMAG, 32'h0001_2345);
    // half gain tells corrected data apart from raw
    xfer(1'b1, OFS_CORRECTION, 32'h0000_2000);
    xfer(1'b1, OFS_FILTER_CFG, 32'h0000_0040);
    send(16'h1234, 8'd24);
    check(32'(popCnt), 32'd24);
    check({16'h0, lastData}, 32'h0925);
    xfer(1'b0, OFS_FLAGS_FIRST, 32'h0);
    check(rdData & 32'h4, 32'h4);
    rdChk(OFS_FLAGS_SECOND, 32'h4);
    xfer(1'b1, OFS_FLAGS_SECOND, 32'h4);
    rdChk(OFS_FLAGS_SECOND, 32'h0);
    xfer(1'b1, OFS_FILTER_CFG, 32'h0000_0041);
    send(16'h1000, 8'd8);
    check({31'h0, converterRateSel}, 32'h1);
    check({16'h0, lastData}, 32'h1007);
    rdChk(OFS_CONV_RESULT, 32'h1007);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, OFS_FILTER_CFG, 32'h0000_00C0 | (32'(c) << 14));
      send(16'h0800, 8'd16);
      check(32'(popCnt), 32'(8 >> c));
      check({16'h0, lastData}, {16'h0, avgLast[c]});
    end
    xfer(1'b1, OFS_FILTER_CFG, 32'h0000_C040);
    send(16'h0800, 8'd4);
    check(32'(popCnt), 32'd4);
    xfer(1'b1, OFS_FILTER_CFG, 32'h0000_0041);
    xfer(1'b1, OFS_XFORM_CFG, 32'h0020_0090);
    xformReady <= 1'b0;
    fork
      send(16'h0100, 8'd12);
      begin
        repeat (80) @(posedge ref_clk);
        check({31'h0, sampleReady}, 32'h0);
        check({31'h0, xformOut.valid}, 32'h1);
        xformReady <= 1'b1;
      end
    join
    check(32'(popCnt), 32'd12);
    check({16'h0, lastData}, 32'h010B);
    check({31'h0, xformOut.valid}, 32'h0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdChk(OFS_FILTER_CFG, RST_FILTER_CFG);
    stopTest();
  end
endmodule

bind afr_chain afr_chain_properties afr_chain_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .tempIn(tempIn),
  .dftResult(dftResult), .xformOut(xformOut), .xformReady(xformReady),
  .converterRateSel(converterRateSel), .hanningEnable(hanningEnable),
  .transformPoints(transformPoints), .bus(bus), .busRsp(busRsp));
`default_nettype wire

// File: include/afr_pkg.sv
// constants and carrier types of the converter filter chain block
// assumes one 250 MHz clock and a 16-bit avalon-mm register window
package afr_pkg;

  // register byte addresses
  localparam logic [15:0] OFS_CONV_RESULT  = 16'h2074;
  localparam logic [15:0] OFS_XFORM_REAL   = 16'h2078;
  localparam logic [15:0] OFS_XFORM_IMAG   = 16'h207C;
  localparam logic [15:0] OFS_NOTCH_RESULT = 16'h2080;
  localparam logic [15:0] OFS_TEMP_RESULT  = 16'h2084;
  localparam logic [15:0] OFS_XFORM_CFG    = 16'h20D0;
  localparam logic [15:0] OFS_FILTER_CFG   = 16'h2044;
  localparam logic [15:0] OFS_CORRECTION   = 16'h2048;
  localparam logic [15:0] OFS_FLAGS_FIRST  = 16'h2050;
  localparam logic [15:0] OFS_FLAGS_SECOND = 16'h2054;

  // reset values and writable-bit masks
  localparam logic [31:0] RST_FILTER_CFG  = 32'h0000_0300;
  localparam logic [31:0] RST_XFORM_CFG   = 32'h0000_0090;
  localparam logic [31:0] RST_CORRECTION  = 32'h0000_4000;
  localparam logic [31:0] MASK_FILTER_CFG = 32'h0000_FFD1;
  localparam logic [31:0] MASK_XFORM_CFG  = 32'h0030_00F1;

  // field positions
  localparam int BIT_RATE_SEL   = 0;
  localparam int BIT_NOTCH_BYP  = 4;
  localparam int BIT_S3_BYP     = 6;
  localparam int BIT_AVG_EN     = 7;
  localparam int POS_S2_RATIO   = 8;
  localparam int POS_S3_RATIO   = 12;
  localparam int POS_AVG_CNT    = 14;
  localparam int POS_XF_INSEL   = 20;
  localparam int POS_XF_POINTS  = 4;
  localparam int BIT_HANNING    = 0;
  localparam int BIT_NOTCH_FLAG = 2;
  localparam int POS_OFFSET     = 16;

  // transform input select codes
  localparam logic [1:0] INSEL_GAIN = 2'h1;
  localparam logic [1:0] INSEL_RAW  = 2'h2;

  // decimation tables, indexed by field code
  localparam int S2_RATIO [12] = '{22, 44, 89, 178, 267, 533,
                                   640, 667, 800, 889, 1067, 1333};
  localparam logic [3:0] S2_CODE_MAX = 4'hB;
  localparam int S3_RATIO [4] = '{5, 4, 2, 5};

  // arithmetic scaling
  localparam int GAIN_FRAC   = 14;
  localparam int S3_NORM     = 24;
  localparam int S2_NORM     = 40;
  localparam int NOTCH_SHIFT = 4;

  // transform input buffer
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_SLACK = 5;

  // reciprocal of ratio**power scaled by 2**shift, folded at elaboration
  function automatic logic [31:0] norm_coef(int n, int p, int sh);
    longint num;
    num = longint'(1) << sh;
    return 32'(num / (longint'(n) ** p));
  endfunction

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } afr_sample_type;

  typedef struct packed {
    logic        valid;
    logic [17:0] re;
    logic [17:0] im;
  } afr_dft_res_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } afr_bus_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } afr_bus_rsp_type;

endpackage

// File: rtl/afr_chain.sv
// converter receive filter chain with result registers and avalon slave
// assumes samples, transform results and bus all run on ref_clk
//
// Summary of operation
// - ratio codes 0111..1011 give 667, 800, 889, 1067, 1333.
// - ratio codes 0000..0110 give 22..640; ratio field resets to 0011.
// - average enable bit 7 routes averaged output into the transform.
// - average count 00..11 averages 2, 4, 8 or 16 samples.
// - enabled averaging overrides the transform input select field.
// - bit 6 bypasses third-order decimator, raw goes to correction.
// - bypass at 800 kHz rate feeds corrected output to transform when averaging is off.
// - bypass path applies no decimation, so no amplitude loss.
// - bit 4 clear applies mains filter; set bypasses it.
// - bit 0 selects 800 kHz or 1.6 MHz raw rate, reset zero.
// - converter result holds 16-bit unsigned raw, sinc3 or sinc2 data.
// - real result register holds 18-bit two's complement value.
// - imaginary result register holds 18-bit two's complement value.
// - notch result register holds filtered second-order output.
// - each new notch result sets bit 2 in both flag registers.
// - temperature result register holds 16-bit sensor channel result.
// - transform configuration resets to 0x00000090.
`timescale 1ns/1ns
`default_nettype none

module afr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AFULL = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             inReady,
  output var  logic             almostFull,
  output var  logic             outValid,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
    logic                        inRdy;
    logic                        outVld;
    logic                        aFull;
  } afr_fifo_state_type;

  afr_fifo_state_type r;
  afr_fifo_state_type n;

  always_comb begin
    logic          push;
    logic          pop;
    logic [CW-1:0] wrIdx;
    push  = inValid && r.inRdy;
    pop   = r.outVld && outReady;
    wrIdx = r.count - CW'(pop);
    n = r;
    // head always sits in word 0, so the output is a plain flop
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.mem[i] = r.mem[i + 1];
      end
    end
    if (push) begin
      n.mem[wrIdx] = inData;
    end
    n.count  = r.count + CW'(push) - CW'(pop);
    n.inRdy  = n.count != CW'(DEPTH);
    n.outVld = n.count != '0;
    n.aFull  = n.count >= CW'(AFULL);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r       <= '0;
      r.inRdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign inReady    = r.inRdy;
  assign almostFull = r.aFull;
  assign outValid   = r.outVld;
  assign outData    = r.mem[0];
endmodule

module afr_chain (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire afr_pkg::afr_sample_type  sampleIn,
  output var  logic                     sampleReady,
  input  wire afr_pkg::afr_sample_type  tempIn,
  input  wire afr_pkg::afr_dft_res_type dftResult,
  output var  afr_pkg::afr_sample_type  xformOut,
  input  wire logic                     xformReady,
  output var  logic                     converterRateSel,
  output var  logic [3:0]               transformPoints,
  output var  logic                     hanningEnable,
  input  wire afr_pkg::afr_bus_req_type bus,
  output var  afr_pkg::afr_bus_rsp_type busRsp
);
  import afr_pkg::*;

  typedef struct packed {
    logic        waitReq;
    logic [31:0] rdData;
    logic [31:0] fcfg;
    logic [31:0] xcfg;
    logic [31:0] corr;
    logic        flag1;
    logic        flag2;
    logic [15:0] convRes;
    logic [15:0] notchRes;
    logic [15:0] tempRes;
    logic [17:0] reRes;
    logic [17:0] imRes;
    logic        sampleReady;
    logic        rawV;
    logic [15:0] raw;
    logic [31:0] s3I1;
    logic [31:0] s3I2;
    logic [31:0] s3I3;
    logic [31:0] s3D1;
    logic [31:0] s3D2;
    logic [31:0] s3D3;
    logic [2:0]  s3Cnt;
    logic        s3V;
    logic [15:0] s3Out;
    logic        goV;
    logic [15:0] go;
    logic [39:0] s2I1;
    logic [39:0] s2I2;
    logic [39:0] s2D1;
    logic [39:0] s2D2;
    logic [10:0] s2Cnt;
    logic        s2V;
    logic [15:0] s2Out;
    logic [15:0] lpY;
    logic [19:0] avSum;
    logic [4:0]  avCnt;
    logic        avV;
    logic [15:0] avOut;
    logic        pushV;
    logic [15:0] pushData;
  } afr_state_type;

  afr_state_type r;
  afr_state_type n;
  logic          fifoInReady;
  logic          fifoAFull;

  function automatic logic [15:0] sat16(logic [71:0] v);
    return (|v[71:16]) ? 16'hFFFF : v[15:0];
  endfunction

  // gain is unsigned with unity at 1 << GAIN_FRAC, offset is signed
  function automatic logic [15:0] correct(logic [15:0] x,
                                          logic [31:0] c);
    logic [33:0]        prod;
    logic signed [34:0] sum;
    prod = {1'b0, x} * {1'b0, c[15:0]};
    sum  = 35'($signed({1'b0, prod[33:GAIN_FRAC]}))
         + 35'($signed(c[POS_OFFSET +: 16]));
    if (sum < 0) begin
      return 16'h0000;
    end
    return (sum > 35'sd65535) ? 16'hFFFF : sum[15:0];
  endfunction

  function automatic logic [10:0] s2Ratio(logic [3:0] code);
    logic [3:0] k;
    k = (code > S2_CODE_MAX) ? S2_CODE_MAX : code;
    return 11'(S2_RATIO[k]);
  endfunction

  function automatic logic [31:0] s2Coef(logic [3:0] code);
    logic [31:0] c;
    c = norm_coef(S2_RATIO[11], 2, S2_NORM);
    unique case (code)
      4'h0: c = norm_coef(S2_RATIO[0], 2, S2_NORM);
      4'h1: c = norm_coef(S2_RATIO[1], 2, S2_NORM);
      4'h2: c = norm_coef(S2_RATIO[2], 2, S2_NORM);
      4'h3: c = norm_coef(S2_RATIO[3], 2, S2_NORM);
      4'h4: c = norm_coef(S2_RATIO[4], 2, S2_NORM);
      4'h5: c = norm_coef(S2_RATIO[5], 2, S2_NORM);
      4'h6: c = norm_coef(S2_RATIO[6], 2, S2_NORM);
      4'h7: c = norm_coef(S2_RATIO[7], 2, S2_NORM);
      4'h8: c = norm_coef(S2_RATIO[8], 2, S2_NORM);
      4'h9: c = norm_coef(S2_RATIO[9], 2, S2_NORM);
      4'hA: c = norm_coef(S2_RATIO[10], 2, S2_NORM);
      default: c = norm_coef(S2_RATIO[11], 2, S2_NORM);
    endcase
    return c;
  endfunction

  function automatic logic [31:0] s3Coef(logic [1:0] code);
    logic [31:0] c;
    unique case (code)
      2'h0: c = norm_coef(S3_RATIO[0], 3, S3_NORM);
      2'h1: c = norm_coef(S3_RATIO[1], 3, S3_NORM);
      2'h2: c = norm_coef(S3_RATIO[2], 3, S3_NORM);
      2'h3: c = norm_coef(S3_RATIO[3], 3, S3_NORM);
    endcase
    return c;
  endfunction

  function automatic logic [31:0] mergeBe(logic [31:0] old,
                                          logic [31:0] wd,
                                          logic [3:0]  be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return v;
  endfunction

  always_comb begin
    logic        s3Byp;
    logic        avgEn;
    logic [1:0]  inSel;
    logic [1:0]  avgCode;
    logic [10:0] ratio;
    logic [2:0]  s3Osr;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [39:0] e1;
    logic [15:0] srcData;
    logic        srcV;
    logic [16:0] diff;
    logic [19:0] sumNow;
    logic        notchNew;
    logic        wrEn;
    logic        clrFlag;
    logic [31:0] rd;
    n        = r;
    s3Byp    = r.fcfg[BIT_S3_BYP];
    avgEn    = r.fcfg[BIT_AVG_EN];
    inSel    = r.xcfg[POS_XF_INSEL +: 2];
    avgCode  = r.fcfg[POS_AVG_CNT +: 2];
    ratio    = s2Ratio(r.fcfg[POS_S2_RATIO +: 4]);
    s3Osr    = 3'(S3_RATIO[r.fcfg[POS_S3_RATIO +: 2]]);
    c1       = '0;
    c2       = '0;
    e1       = '0;
    srcData  = '0;
    srcV     = 1'b0;
    diff     = '0;
    sumNow   = '0;
    notchNew = 1'b0;
    n.rawV   = 1'b0;
    n.s3V    = 1'b0;
    n.goV    = 1'b0;
    n.s2V    = 1'b0;
    n.avV    = 1'b0;
    n.pushV  = 1'b0;
    // ready leaves room for samples already inside the pipeline
    n.sampleReady = !fifoAFull;

    if (sampleIn.valid && r.sampleReady) begin
      n.rawV = 1'b1;
      n.raw  = sampleIn.data;
    end

    // third-order decimator: integrators per sample, combs per output
    if (r.rawV && !s3Byp) begin
      n.s3I1  = r.s3I1 + 32'(r.raw);
      n.s3I2  = r.s3I2 + r.s3I1;
      n.s3I3  = r.s3I3 + r.s3I2;
      n.s3Cnt = r.s3Cnt + 3'h1;
      if (r.s3Cnt >= s3Osr - 3'h1) begin
        c1      = r.s3I3 - r.s3D1;
        c2      = c1 - r.s3D2;
        n.s3D1  = r.s3I3;
        n.s3D2  = c1;
        n.s3D3  = c2;
        n.s3Cnt = '0;
        n.s3V   = 1'b1;
        n.s3Out = sat16(72'(({32'h0, c2 - r.s3D3} * s3Coef(
                    r.fcfg[POS_S3_RATIO +: 2])) >> S3_NORM));
      end
    end

    if (s3Byp ? r.rawV : r.s3V) begin
      n.goV = 1'b1;
      n.go  = correct(s3Byp ? r.raw : r.s3Out, r.corr);
    end

    // second-order decimator on the corrected stream
    if (r.goV) begin
      n.s2I1  = r.s2I1 + 40'(r.go);
      n.s2I2  = r.s2I2 + r.s2I1;
      n.s2Cnt = r.s2Cnt + 11'h1;
      // a ratio lowered mid-frame closes the frame at once
      if (r.s2Cnt >= ratio - 11'h1) begin
        e1      = r.s2I2 - r.s2D1;
        n.s2D1  = r.s2I2;
        n.s2D2  = e1;
        n.s2Cnt = '0;
        n.s2V   = 1'b1;
        n.s2Out = sat16(72'(({32'h0, e1 - r.s2D2} * s2Coef(
                    r.fcfg[POS_S2_RATIO +: 4])) >> S2_NORM));
      end
    end

    if (r.s2V) begin
      notchNew = 1'b1;
      if (r.fcfg[BIT_NOTCH_BYP]) begin
        n.notchRes = r.s2Out;
      end else begin
        diff       = {1'b0, r.s2Out} - {1'b0, r.lpY};
        n.lpY      = r.lpY + 16'($signed(diff) >>> NOTCH_SHIFT);
        n.notchRes = n.lpY;
      end
    end

    if (!avgEn) begin
      n.avSum = '0;
      n.avCnt = '0;
    end else if (r.goV) begin
      sumNow  = r.avSum + 20'(r.go);
      n.avSum = sumNow;
      n.avCnt = r.avCnt + 5'h1;
      if (r.avCnt == (5'h2 << avgCode) - 5'h1) begin
        n.avV   = 1'b1;
        n.avOut = 16'(sumNow >> (3'(avgCode) + 3'h1));
        n.avSum = '0;
        n.avCnt = '0;
      end
    end

    if (avgEn) begin
      srcV    = r.avV;
      srcData = r.avOut;
    end else if (s3Byp && !r.fcfg[BIT_RATE_SEL]) begin
      srcV    = r.goV;
      srcData = r.go;
    end else if (inSel == INSEL_RAW) begin
      srcV    = r.rawV;
      srcData = r.raw;
    end else if (inSel == INSEL_GAIN) begin
      srcV    = r.goV;
      srcData = r.go;
    end else begin
      srcV    = r.s2V;
      srcData = r.s2Out;
    end
    if (srcV && fifoInReady) begin
      n.pushV    = 1'b1;
      n.pushData = srcData;
    end

    if (inSel == INSEL_RAW) begin
      if (r.rawV) begin
        n.convRes = r.raw;
      end
    end else if (inSel == INSEL_GAIN) begin
      if (r.goV) begin
        n.convRes = r.go;
      end
    end else if (r.s2V) begin
      n.convRes = r.s2Out;
    end

    if (tempIn.valid) begin
      n.tempRes = tempIn.data;
    end
    if (dftResult.valid) begin
      n.reRes = dftResult.re;
      n.imRes = dftResult.im;
    end

    // register reads and writes, one cycle of wait then the answer
    rd = '0;
    unique case (bus.address)
      OFS_CONV_RESULT:  rd = {16'h0, r.convRes};
      OFS_XFORM_REAL:   rd = {14'h0, r.reRes};
      OFS_XFORM_IMAG:   rd = {14'h0, r.imRes};
      OFS_NOTCH_RESULT: rd = {16'h0, r.notchRes};
      OFS_TEMP_RESULT:  rd = {16'h0, r.tempRes};
      OFS_XFORM_CFG:    rd = r.xcfg;
      OFS_FILTER_CFG:   rd = r.fcfg;
      OFS_CORRECTION:   rd = r.corr;
      OFS_FLAGS_FIRST:  rd[BIT_NOTCH_FLAG] = r.flag1;
      OFS_FLAGS_SECOND: rd[BIT_NOTCH_FLAG] = r.flag2;
      default:          rd = '0;
    endcase
    wrEn      = bus.write && !r.waitReq;
    n.waitReq = 1'b1;
    if (r.waitReq && (bus.read || bus.write)) begin
      n.waitReq = 1'b0;
      n.rdData  = bus.read ? rd : 32'h0;
    end
    if (wrEn) begin
      unique case (bus.address)
        OFS_FILTER_CFG: n.fcfg = mergeBe(r.fcfg, bus.writedata,
                                         bus.byteenable) & MASK_FILTER_CFG;
        OFS_XFORM_CFG:  n.xcfg = mergeBe(r.xcfg, bus.writedata,
                                         bus.byteenable) & MASK_XFORM_CFG;
        OFS_CORRECTION: n.corr = mergeBe(r.corr, bus.writedata,
                                         bus.byteenable);
        default: ;
      endcase
    end

    // notch sets both flags
    // a new result in the clearing cycle survives the clear
    clrFlag = wrEn && bus.byteenable[0] && bus.writedata[BIT_NOTCH_FLAG];
    n.flag1 = (r.flag1 && !(clrFlag && bus.address == OFS_FLAGS_FIRST))
            || notchNew;
    n.flag2 = (r.flag2 && !(clrFlag && bus.address == OFS_FLAGS_SECOND))
            || notchNew;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r         <= '0;
      r.waitReq <= 1'b1;
      r.fcfg    <= RST_FILTER_CFG;
      r.xcfg    <= RST_XFORM_CFG;
      r.corr    <= RST_CORRECTION;
    end else begin
      r <= n;
    end
  end

  afr_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AFULL (FIFO_DEPTH - FIFO_SLACK)
  ) u_xform_fifo (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .inValid    (r.pushV),
    .inData     (r.pushData),
    .inReady    (fifoInReady),
    .almostFull (fifoAFull),
    .outValid   (xformOut.valid),
    .outData    (xformOut.data),
    .outReady   (xformReady)
  );

  assign sampleReady          = r.sampleReady;
  assign converterRateSel     = r.fcfg[BIT_RATE_SEL];
  assign transformPoints      = r.xcfg[POS_XF_POINTS +: 4];
  assign hanningEnable        = r.xcfg[BIT_HANNING];
  assign busRsp.readdata      = r.rdData;
  assign busRsp.waitrequest   = r.waitReq;
endmodule

`default_nettype wire
